// ---- verification/elc_csr_checker.sv ----
// Port assertions for the link and slot register block.
`timescale 1ns/100ps
`default_nettype none
module elc_csr_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              MCLK,
  input wire logic              RESETN,
  input wire logic              REVERSE_STRAP,
  input wire logic              HOTPLUG_STRAP,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic [31:0]       WDATA,
  input wire logic [3:0]        WSTRB,
  input wire logic              WVALID,
  input wire logic              WREADY,
  input wire logic              BVALID,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic [31:0]       RDATA,
  input wire logic              RVALID,
  input wire logic [1:0]        PWR_ENTRY,
  input wire logic              LINK_DISABLE,
  input wire logic              RETRAIN_LINK
);
  logic [ADDR_W-1:0] rd_addr;
  logic              hp_on;
  logic              wr_both;
  assign hp_on   = HOTPLUG_STRAP & REVERSE_STRAP;
  assign wr_both = AWVALID & AWREADY & WVALID & WREADY;
  // The read address is kept so that the returned word can be judged per register.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) rd_addr <= '0;
    else if (ARVALID && ARREADY) rd_addr <= ARADDR;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_pwr_write: assert property (
    wr_both && AWADDR == 8'hC0 && WSTRB[0] |-> ##2 PWR_ENTRY == $past(WDATA[1:0], 2))
    else $error("power entry field not written");
  a_rcb_zero: assert property (
    RVALID && rd_addr == 8'hC0 |-> RDATA[3:2] == 2'h0 && RDATA[15:8] == 8'h00)
    else $error("link control zero bits read nonzero");
  a_fwd_locked: assert property (!REVERSE_STRAP |-> !LINK_DISABLE && !RETRAIN_LINK)
    else $error("forward bridge link bits changed");
  a_speed_code: assert property (
    RVALID && rd_addr == 8'hC0 |-> RDATA[19:16] == 4'h1 && RDATA[31:28] == 4'h1)
    else $error("link speed or top status bits wrong");
  a_hp_bits: assert property (
    RVALID && rd_addr == 8'hC4 |-> RDATA == {25'h0, hp_on, 1'b0, {3{hp_on}}, 1'b0, hp_on})
    else $error("slot capability word wrong");
  a_slot_resv: assert property (
    RVALID && rd_addr == 8'hC8 |-> RDATA[15:11] == 5'h00 && RDATA[31:23] == 9'h000)
    else $error("slot reserved bits nonzero");
  a_read_turn: assert property (ARVALID && ARREADY |=> RVALID [*1])
    else $error("read answer late");
  a_write_turn: assert property (wr_both |-> ##2 BVALID)
    else $error("write answer late");
endmodule : elc_csr_checker
bind elc_csr elc_csr_checker #(.ADDR_W(ADDR_W)) i_elc_csr_checker (.*);
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the link and slot register block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] a; logic [31:0] v; logic [3:0] s; logic [31:0] x;} elc_row_s;
  localparam logic [15:0] ls = 16'h1441;
  localparam logic [15:0] ss = 16'h0055;
  logic        MCLK, RESETN, REVERSE_STRAP, HOTPLUG_STRAP, LINK_TRAIN_ERROR, LINK_TRAINING;
  logic [5:0]  LINK_WIDTH;
  logic [6:0]  SLOT_EVENTS;
  logic [1:0]  PWR_ENTRY, BRESP, RRESP, r;
  logic        LINK_DISABLE, RETRAIN_LINK, COMMON_CLOCK, EXTENDED_SYNC;
  logic [10:0] SLOT_CONTROL;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0]  WSTRB;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  int          mismatches, comparisons;
  elc_row_s    rows [8] = '{
    '{8'hC0, 32'hFFFF_FFFF, 4'hF, {ls, 16'h00F3}}, '{8'hC0, 32'h0000_0001, 4'h1, {ls, 16'h0001}},
    '{8'hC0, 32'h0000_0002, 4'h1, {ls, 16'h0002}}, '{8'hC0, 32'h0000_0000, 4'h1, {ls, 16'h0000}},
    '{8'hC0, 32'h0000_00FF, 4'h2, {ls, 16'h0000}}, '{8'hC8, 32'hFFFF_FFFF, 4'hF, {ss, 16'h07FF}},
    '{8'hC8, 32'h0000_0000, 4'h1, {ss, 16'h0700}}, '{8'hC4, 32'hFFFF_FFFF, 4'hF, 32'h0000_005D}};
  elc_csr i_elc_csr (.*);
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Straps only move while reset is held, since the block captures them once.
  task automatic rst(input logic rev, input logic hp);
    RESETN <= 1'b0;
    {REVERSE_STRAP, HOTPLUG_STRAP} <= {rev, hp};
    repeat (12) @(posedge MCLK);
    RESETN <= 1'b1;
    repeat (6) @(posedge MCLK);
  endtask : rst
  // Ready is sampled mid-cycle so the release lands just after the taking edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge MCLK);
    {AWADDR, WDATA, WSTRB} <= {a, v, s};
    {AWVALID, WVALID, BREADY} <= 3'b111;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge MCLK);
      {ta, tw, tb, r} = {AWREADY, WREADY, BVALID, BRESP};
      @(posedge MCLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
      if (tb) BREADY <= 1'b0;
    end
    mismatches += int'(!tb);
    if (!tb) end_sim();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge MCLK);
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'b11;
    for (int n = 0; n < 50 && !tr; n++) begin
      @(negedge MCLK);
      {ta, tr, d, r} = {ARREADY, RVALID, RDATA, RRESP};
      @(posedge MCLK);
      if (ta) ARVALID <= 1'b0;
      if (tr) RREADY <= 1'b0;
    end
    mismatches += int'(!tr);
    if (!tr) end_sim();
  endtask : rd
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, WDATA, WSTRB, ARADDR} <= '0;
    {LINK_WIDTH, LINK_TRAIN_ERROR, LINK_TRAINING, SLOT_EVENTS} <= {6'h04, 1'b1, 1'b0, 7'h55};
    rst(1'b1, 1'b1);
    rd(8'hC0);
    chk("link reset", d, {ls, 16'h0000});
    rd(8'hC8);
    chk("slot reset", d, {ss, 16'h0000});
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].a, rows[i].v, rows[i].s);
      chk("write resp", {30'h0, r}, {30'h0, elc_pkg::RESP_OKAY});
      rd(rows[i].a);
      chk("readback", d, rows[i].x);
      chk("read resp", {30'h0, r}, {30'h0, elc_pkg::RESP_OKAY});
    end
    chk("slot pins", {21'h0, SLOT_CONTROL}, 32'h0000_0700);
    wr(8'h10, 32'hFFFF_FFFF, 4'hF);
    chk("unmapped write", {30'h0, r}, {30'h0, elc_pkg::RESP_SLVERR});
    rd(8'h10);
    chk("unmapped resp", {30'h0, r}, {30'h0, elc_pkg::RESP_SLVERR});
    chk("unmapped data", d, 32'h0000_0000);
    rst(1'b0, 1'b1);
    wr(8'hC0, 32'h0000_00FF, 4'h1);
    rd(8'hC0);
    chk("forward link", d, {ls, 16'h00C3});
    chk("forward pins", {26'h0, PWR_ENTRY, LINK_DISABLE, RETRAIN_LINK, COMMON_CLOCK, EXTENDED_SYNC},
        32'h0000_0033);
    rd(8'hC4);
    chk("forward cap", d, 32'h0000_0000);
    rst(1'b1, 1'b0);
    rd(8'hC4);
    chk("no hot plug cap", d, 32'h0000_0000);
    wr(8'hC0, 32'h0000_0030, 4'h1);
    chk("reverse pins", {26'h0, PWR_ENTRY, LINK_DISABLE, RETRAIN_LINK, COMMON_CLOCK, EXTENDED_SYNC},
        32'h0000_000C);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

// ---- verilog/elc_csr.sv ----
// Link and slot configuration registers reached over AXI4-Lite.
// Summary of operation
// (R1) Two-bit power-state entry control, writable, resets to 00.
// (R2) Read completion boundary bit always reads zero.
// (R3) Link disable and retrain are read-only forward, writable reverse; reset zero.
// (R4) Negotiated link speed field is read-only, reads code 1 for 2.5Gb/s.
// (R5) Hot-plug presence and capable bits read 1 only when strapped on in reverse.
// (R6) With hot plug disabled those slot capability bits read 0.
// (R7) Writes to read-only or reserved fields ignored; reserved fields read zero.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module elc_csr #(
  parameter int ADDR_W = 8
) (
  input  wire logic              MCLK,
  input  wire logic              RESETN,
  input  wire logic              REVERSE_STRAP,
  input  wire logic              HOTPLUG_STRAP,
  input  wire logic [5:0]        LINK_WIDTH,
  input  wire logic              LINK_TRAIN_ERROR,
  input  wire logic              LINK_TRAINING,
  input  wire logic [6:0]        SLOT_EVENTS,
  output logic [1:0]             PWR_ENTRY,
  output logic                   LINK_DISABLE,
  output logic                   RETRAIN_LINK,
  output logic                   COMMON_CLOCK,
  output logic                   EXTENDED_SYNC,
  output logic [10:0]            SLOT_CONTROL,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY
);
  // The register offsets need at least eight address bits.
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------------------
  // Input synchronisers and strap capture
  // ----------------------------------------------------------------------------
  logic [16:0] sync1;
  logic [16:0] sync2;
  logic        strap_done;
  logic        reverse;
  logic        hotplug;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1 <= 17'h0_0000;
      sync2 <= 17'h0_0000;
    end else begin
      sync1 <= {SLOT_EVENTS, LINK_TRAINING, LINK_TRAIN_ERROR, LINK_WIDTH, REVERSE_STRAP,
                HOTPLUG_STRAP};
      sync2 <= sync1;
    end
  end

  // Straps are caught once, three edges after release, when the second synchroniser stage
  // holds the pin level; later pin motion has no effect.
  logic [1:0] strap_arm;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      strap_arm  <= 2'b00;
      strap_done <= 1'b0;
      reverse    <= 1'b0;
      hotplug    <= 1'b0;
    end else begin
      strap_arm <= {strap_arm[0], 1'b1};
      if (strap_arm[1] && !strap_done) begin
        strap_done <= 1'b1;
        reverse    <= sync2[1];
        hotplug    <= sync2[0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // AXI write path
  // ----------------------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;
  logic              do_write;
  assign AWREADY  = !aw_held && !BVALID;
  assign WREADY   = !w_held && !BVALID;
  assign do_write = aw_held && w_held && !BVALID;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= elc_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= hit(aw_addr) ? elc_pkg::RESP_OKAY : elc_pkg::RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = (a == ADDR_W'(elc_pkg::ADDR_LINK)) || (a == ADDR_W'(elc_pkg::ADDR_SLOTCAP)) ||
          (a == ADDR_W'(elc_pkg::ADDR_SLOT));
  endfunction : hit

  // ----------------------------------------------------------------------------
  // Writable fields
  // ----------------------------------------------------------------------------
  logic wr_link;
  logic wr_slot;
  assign wr_link = do_write && (aw_addr == ADDR_W'(elc_pkg::ADDR_LINK)) && w_strb[0];
  assign wr_slot = do_write && (aw_addr == ADDR_W'(elc_pkg::ADDR_SLOT));

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      PWR_ENTRY     <= elc_pkg::PWR_RESET; // R1
      LINK_DISABLE  <= 1'b0; // R3
      RETRAIN_LINK  <= 1'b0; // R3
      COMMON_CLOCK  <= 1'b0;
      EXTENDED_SYNC <= 1'b0;
    end else if (wr_link) begin
      PWR_ENTRY     <= w_data[elc_pkg::LC_PWR_LSB +: 2]; // R1
      COMMON_CLOCK  <= w_data[elc_pkg::LC_CCLK_BIT];
      EXTENDED_SYNC <= w_data[elc_pkg::LC_XSYNC_BIT];
      // A forward bridge keeps both link actions at zero.
      if (reverse) begin
        LINK_DISABLE <= w_data[elc_pkg::LC_DISABLE_BIT]; // R3
        RETRAIN_LINK <= w_data[elc_pkg::LC_RETRAIN_BIT]; // R3
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      SLOT_CONTROL <= elc_pkg::SCTL_RESET;
    end else if (wr_slot) begin
      if (w_strb[0]) begin
        SLOT_CONTROL[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        SLOT_CONTROL[10:8] <= w_data[10:8]; // R7
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  logic        hp_on;
  logic [31:0] rd_mux;
  assign hp_on   = hotplug && reverse; // R5 R6
  assign ARREADY = !RVALID;

  always_comb begin
    rd_mux = 32'h0000_0000; // R7
    if (ARADDR == ADDR_W'(elc_pkg::ADDR_LINK)) begin
      rd_mux[elc_pkg::LC_PWR_LSB +: 2]   = PWR_ENTRY;
      rd_mux[elc_pkg::LC_RCB_BIT]        = 1'b0; // R2
      rd_mux[elc_pkg::LC_DISABLE_BIT]    = LINK_DISABLE;
      rd_mux[elc_pkg::LC_RETRAIN_BIT]    = RETRAIN_LINK;
      rd_mux[elc_pkg::LC_CCLK_BIT]       = COMMON_CLOCK;
      rd_mux[elc_pkg::LC_XSYNC_BIT]      = EXTENDED_SYNC;
      rd_mux[elc_pkg::LS_SPEED_LSB +: 4] = elc_pkg::SPEED_2G5; // R4
      rd_mux[elc_pkg::LS_WIDTH_LSB +: 6] = strap_done ? sync2[7:2] : elc_pkg::WIDTH_X1;
      rd_mux[elc_pkg::LS_TERR_BIT]       = sync2[8];
      rd_mux[elc_pkg::LS_TRAIN_BIT]      = sync2[9];
      rd_mux[elc_pkg::LS_SCLK_BIT]       = elc_pkg::SCLK_RESET;
    end else if (ARADDR == ADDR_W'(elc_pkg::ADDR_SLOTCAP)) begin
      rd_mux[elc_pkg::SC_BUTTON_BIT] = hp_on; // R5 R6
      rd_mux[elc_pkg::SC_LATCH_BIT]  = hp_on; // R5 R6
      rd_mux[elc_pkg::SC_ATTN_BIT]   = hp_on; // R5 R6
      rd_mux[elc_pkg::SC_PIND_BIT]   = hp_on; // R5 R6
      rd_mux[elc_pkg::SC_HPCAP_BIT]  = hp_on; // R5 R6
    end else if (ARADDR == ADDR_W'(elc_pkg::ADDR_SLOT)) begin
      rd_mux[elc_pkg::SCTL_WIDTH-1:0]            = SLOT_CONTROL;
      rd_mux[elc_pkg::SS_LSB +: elc_pkg::SS_WIDTH] = sync2[16:10];
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= elc_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= rd_mux;
      RRESP  <= hit(ARADDR) ? elc_pkg::RESP_OKAY : elc_pkg::RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end
endmodule : elc_csr
`default_nettype wire

// ---- verilog/elc_pkg.sv ----
// Package of offsets, field positions and reset values for the link and slot registers.
package elc_pkg;
  // ----------------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_LINK    = 8'hC0;
  localparam logic [7:0] ADDR_SLOTCAP = 8'hC4;
  localparam logic [7:0] ADDR_SLOT    = 8'hC8;

  // ----------------------------------------------------------------------------
  // Link control and status fields
  // ----------------------------------------------------------------------------
  localparam int LC_PWR_LSB     = 0;
  localparam int LC_RCB_BIT     = 3;
  localparam int LC_DISABLE_BIT = 4;
  localparam int LC_RETRAIN_BIT = 5;
  localparam int LC_CCLK_BIT    = 6;
  localparam int LC_XSYNC_BIT   = 7;
  localparam int LS_SPEED_LSB   = 16;
  localparam int LS_WIDTH_LSB   = 20;
  localparam int LS_TERR_BIT    = 26;
  localparam int LS_TRAIN_BIT   = 27;
  localparam int LS_SCLK_BIT    = 28;
  localparam logic [1:0] PWR_RESET   = 2'h0;
  localparam logic [3:0] SPEED_2G5   = 4'h1;
  localparam logic [5:0] WIDTH_X1    = 6'h01;
  localparam logic       SCLK_RESET  = 1'b1;

  // ----------------------------------------------------------------------------
  // Slot capability, control and status fields
  // ----------------------------------------------------------------------------
  localparam int SC_BUTTON_BIT  = 0;
  localparam int SC_LATCH_BIT   = 2;
  localparam int SC_ATTN_BIT    = 3;
  localparam int SC_PIND_BIT    = 4;
  localparam int SC_HPCAP_BIT   = 6;
  localparam int SCTL_WIDTH     = 11;
  localparam logic [10:0] SCTL_RESET = 11'h000;
  localparam int SS_LSB         = 16;
  localparam int SS_WIDTH       = 7;

  // ----------------------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : elc_pkg
